/* File: src/mfio_pkg.sv */
// package for the multi-function analog input and output terminal selector
package mfio_pkg;
   // =====================================================================
   // register map (byte addresses, one word per register)
   localparam logic [7:0] MFIO_ADDR_RELAY_FN = 8'h00;
   localparam logic [7:0] MFIO_ADDR_OC1_FN = 8'h04;
   localparam logic [7:0] MFIO_ADDR_OC2_FN = 8'h08;
   localparam logic [7:0] MFIO_ADDR_AUX_FN = 8'h0C;
   localparam logic [7:0] MFIO_ADDR_AUX_TYPE = 8'h10;
   localparam logic [7:0] MFIO_ADDR_AUX_BIAS = 8'h14;
   localparam logic [7:0] MFIO_ADDR_TERM_STAT = 8'h18;

   // =====================================================================
   // reset values and legal ranges
   localparam logic [7:0] MFIO_RST_RELAY_FN = 8'h00;
   localparam logic [7:0] MFIO_RST_OC1_FN = 8'h01;
   localparam logic [7:0] MFIO_RST_OC2_FN = 8'h02;
   localparam logic [7:0] MFIO_RST_AUX_FN = 8'h00;
   localparam logic [7:0] MFIO_RST_AUX_TYPE = 8'h00;
   localparam logic [7:0] MFIO_RST_AUX_BIAS = 8'h0A;
   localparam logic [7:0] MFIO_MAX_AUX_FN = 8'h04;
   localparam logic [7:0] MFIO_MAX_AUX_TYPE = 8'h01;
   localparam logic [7:0] MFIO_MAX_AUX_BIAS = 8'h32;

   // =====================================================================
   // analog function settings
   localparam logic [7:0] MFIO_AF_OFF = 8'h00;
   localparam logic [7:0] MFIO_AF_FREF = 8'h01;
   localparam logic [7:0] MFIO_AF_GAIN = 8'h02;
   localparam logic [7:0] MFIO_AF_BIAS = 8'h03;
   localparam logic [7:0] MFIO_AF_VOFS = 8'h04;

   // =====================================================================
   // analog scaling: 10-bit sample, 16-bit fraction of full scale
   localparam logic [9:0] MFIO_CUR_ZERO = 10'h0CD; // 4 mA on a 20 mA scale
   localparam logic [2:0] MFIO_CUR_MUL = 3'h5;
   localparam int MFIO_CUR_SHIFT = 2;
   localparam logic [9:0] MFIO_PCT_SCALE = 10'h28F; // 65535 / 100
   localparam int MFIO_LVL_SHIFT = 10;

   // =====================================================================
   // output function codes
   localparam logic [7:0] MFIO_OC_FAULT = 8'h00;
   localparam logic [7:0] MFIO_OC_RUN = 8'h01;
   localparam logic [7:0] MFIO_OC_AGREE = 8'h02;
   localparam logic [7:0] MFIO_OC_ZERO = 8'h03;
   localparam logic [7:0] MFIO_OC_FDET1 = 8'h04;
   localparam logic [7:0] MFIO_OC_FDET2 = 8'h05;
   localparam logic [7:0] MFIO_OC_OT_NO = 8'h06;
   localparam logic [7:0] MFIO_OC_OT_NC = 8'h07;
   localparam logic [7:0] MFIO_OC_UT_NO = 8'h08;
   localparam logic [7:0] MFIO_OC_UT_NC = 8'h09;
   localparam logic [7:0] MFIO_OC_MINOR = 8'h0A;
   localparam logic [7:0] MFIO_OC_BBLK = 8'h0B;
   localparam logic [7:0] MFIO_OC_LOCAL = 8'h0C;
   localparam logic [7:0] MFIO_OC_READY = 8'h0D;
   localparam logic [7:0] MFIO_OC_RETRY = 8'h0E;
   localparam logic [7:0] MFIO_OC_UV = 8'h0F;
   localparam logic [7:0] MFIO_OC_REV = 8'h10;
   localparam logic [7:0] MFIO_OC_SRCH = 8'h11;
   localparam logic [7:0] MFIO_OC_FBLOSS = 8'h13;
   localparam logic [7:0] MFIO_OC_REFLOSS = 8'h14;
   localparam logic [7:0] MFIO_OC_OHEAT = 8'h15;
   localparam logic [7:0] MFIO_OC_MOTOR2 = 8'h16;

   // drive conditions from same-clock drive logic
   typedef struct packed {
      logic fault;
      logic run_cmd;
      logic volt_out;
      logic freq_agree;
      logic overtorque;
      logic undertorque;
      logic minor_alarm;
      logic base_block;
      logic local_sel;
      logic ready;
      logic fault_retry;
      logic undervolt;
      logic reverse;
      logic speed_search;
      logic fb_loss;
      logic ref_loss;
      logic overheat;
      logic motor2;
      logic [15:0] out_freq;
      logic [15:0] min_freq;
      logic [15:0] frequency_detect_level;
   } mfio_status_t;

   // register port
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } mfio_bus_req_t;
endpackage : mfio_pkg

/* File: src/mfio_sel.sv */
// multi-function analog input and output terminal selector
// =====================================================================
// Overview of operation
// - function zero ignores auxiliary input entirely
// - function one: aux replaces step-two reference
// - function two: scaled master times aux gain
// - function three: add aux bias to master
// - function four: add aux offset to voltage
// - 400 V class doubles voltage offset
// - signal type: zero voltage, one current
// - bias amount 0 to 50 percent, reset 10
// - three function codes: relay, two collectors
// - code 0 fault, code 10 minor alarm
// - code 1 run command or output voltage
// - code 2 frequency agree
// - code 3 output below minimum frequency
// - code 4 at/above, 5 at/below level
// - codes 6-9 over/undertorque, open and closed
// - code 11 output stage switched off
// - code 12 local operation selected
// - code 13 no fault and ready
// - code 14 fault retry, 15 undervoltage
// - code 16 reverse, 17 speed search
// - code 19 feedback loss, 20 reference loss
// - code 21 overheat, 22 second motor
module mfio_sel
   import mfio_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire mfio_bus_req_t bus_i,
   output logic [31:0] rd_data_o,
   input wire mfio_status_t status_i,
   input wire logic [9:0] aux_sample_i,
   input wire logic [15:0] master_ref_i,
   input wire logic [15:0] second_step_reference_i,
   input wire logic step_two_sel_i,
   input wire logic [15:0] vf_voltage_i,
   input wire logic class400_i,
   output logic [15:0] freq_ref_o,
   output logic [15:0] volt_ref_o,
   output logic relay_contact_a_o,
   output logic relay_contact_b_o,
   output logic open_collector_one_o,
   output logic open_collector_two_o
);
   // =====================================================================
   // reset release
   logic rst_s1_ff;
   logic rst_b_ff;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_b_ff <= rst_s1_ff;
      end
   end

   // =====================================================================
   // terminal condition decode, shared by all three terminals
   function automatic logic term_sel(input logic [7:0] code, input mfio_status_t st);
      logic hit;
      hit = 1'b0;
      case (code)
         MFIO_OC_FAULT: hit = st.fault;
         MFIO_OC_RUN: hit = st.run_cmd | st.volt_out;
         MFIO_OC_AGREE: hit = st.freq_agree;
         MFIO_OC_ZERO: hit = st.out_freq < st.min_freq;
         MFIO_OC_FDET1: hit = st.out_freq >= st.frequency_detect_level;
         MFIO_OC_FDET2: hit = st.out_freq <= st.frequency_detect_level;
         MFIO_OC_OT_NO: hit = st.overtorque;
         MFIO_OC_OT_NC: hit = !st.overtorque;
         MFIO_OC_UT_NO: hit = st.undertorque;
         MFIO_OC_UT_NC: hit = !st.undertorque;
         MFIO_OC_MINOR: hit = st.minor_alarm;
         MFIO_OC_BBLK: hit = st.base_block;
         MFIO_OC_LOCAL: hit = st.local_sel;
         MFIO_OC_READY: hit = !st.fault & st.ready;
         MFIO_OC_RETRY: hit = st.fault_retry;
         MFIO_OC_UV: hit = st.undervolt;
         MFIO_OC_REV: hit = st.reverse;
         MFIO_OC_SRCH: hit = st.speed_search;
         MFIO_OC_FBLOSS: hit = st.fb_loss;
         MFIO_OC_REFLOSS: hit = st.ref_loss;
         MFIO_OC_OHEAT: hit = st.overheat;
         MFIO_OC_MOTOR2: hit = st.motor2;
         // code 18 has no source in this block, so it reads as open
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // saturating 16-bit add
   function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[16] ? 16'hFFFF : s[15:0];
   endfunction

   // =====================================================================
   // register file
   logic [7:0] relay_output_function_ff;
   logic [7:0] first_open_collector_function_ff;
   logic [7:0] second_open_collector_function_ff;
   logic [7:0] aux_analog_function_ff;
   logic [7:0] aux_analog_signal_type_ff;
   logic [7:0] aux_bias_amount_ff;
   logic [31:0] rd_data_ff;

   wire logic [7:0] wr_byte = bus_i.wdata[7:0];
   wire logic wr_relay = bus_i.wr && bus_i.addr == MFIO_ADDR_RELAY_FN;
   wire logic wr_oc1 = bus_i.wr && bus_i.addr == MFIO_ADDR_OC1_FN;
   wire logic wr_oc2 = bus_i.wr && bus_i.addr == MFIO_ADDR_OC2_FN;
   // out-of-range settings are refused and the old value stays
   wire logic wr_afn = bus_i.wr && bus_i.addr == MFIO_ADDR_AUX_FN
                       && wr_byte <= MFIO_MAX_AUX_FN;
   wire logic wr_atype = bus_i.wr && bus_i.addr == MFIO_ADDR_AUX_TYPE
                         && wr_byte <= MFIO_MAX_AUX_TYPE;
   wire logic wr_abias = bus_i.wr && bus_i.addr == MFIO_ADDR_AUX_BIAS
                         && wr_byte <= MFIO_MAX_AUX_BIAS;

   always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         relay_output_function_ff <= MFIO_RST_RELAY_FN;
         first_open_collector_function_ff <= MFIO_RST_OC1_FN;
         second_open_collector_function_ff <= MFIO_RST_OC2_FN;
         aux_analog_function_ff <= MFIO_RST_AUX_FN;
         aux_analog_signal_type_ff <= MFIO_RST_AUX_TYPE;
         aux_bias_amount_ff <= MFIO_RST_AUX_BIAS;
      end else begin
         if (wr_relay) relay_output_function_ff <= wr_byte;
         if (wr_oc1) first_open_collector_function_ff <= wr_byte;
         if (wr_oc2) second_open_collector_function_ff <= wr_byte;
         if (wr_afn) aux_analog_function_ff <= wr_byte;
         if (wr_atype) aux_analog_signal_type_ff <= wr_byte;
         if (wr_abias) aux_bias_amount_ff <= wr_byte;
      end
   end

   // =====================================================================
   // read path: data stands in the cycle after the strobe only
   logic [31:0] nxt_rd_data;
   logic [3:0] term_state;

   always_comb begin
      nxt_rd_data = 32'h0000_0000;
      case (bus_i.addr)
         MFIO_ADDR_RELAY_FN: nxt_rd_data[7:0] = relay_output_function_ff;
         MFIO_ADDR_OC1_FN: nxt_rd_data[7:0] = first_open_collector_function_ff;
         MFIO_ADDR_OC2_FN: nxt_rd_data[7:0] = second_open_collector_function_ff;
         MFIO_ADDR_AUX_FN: nxt_rd_data[7:0] = aux_analog_function_ff;
         MFIO_ADDR_AUX_TYPE: nxt_rd_data[7:0] = aux_analog_signal_type_ff;
         MFIO_ADDR_AUX_BIAS: nxt_rd_data[7:0] = aux_bias_amount_ff;
         MFIO_ADDR_TERM_STAT: nxt_rd_data[3:0] = term_state;
         default: nxt_rd_data = 32'h0000_0000;
      endcase
      if (!bus_i.rd) nxt_rd_data = 32'h0000_0000;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) rd_data_ff <= 32'h0000_0000;
      else rd_data_ff <= nxt_rd_data;
   end

   assign rd_data_o = rd_data_ff;

   // =====================================================================
   // auxiliary input level, normalised to 10 bits
   wire logic cur_mode = aux_analog_signal_type_ff[0];
   wire logic [9:0] cur_off = aux_sample_i < MFIO_CUR_ZERO ? 10'h000
                              : aux_sample_i - MFIO_CUR_ZERO;
   wire logic [12:0] cur_mul = {3'h0, cur_off} * {10'h000, MFIO_CUR_MUL};
   // the 4 mA floor maps a broken loop to zero rather than a negative level
   wire logic [9:0] aux_lvl = cur_mode ? cur_mul[MFIO_CUR_SHIFT +: 10] : aux_sample_i;

   // =====================================================================
   // frequency reference
   wire logic [15:0] step_ref = step_two_sel_i ? second_step_reference_i : master_ref_i;
   wire logic [15:0] aux_fref = {aux_lvl, 6'h00};
   wire logic [25:0] gain_prod = {10'h000, master_ref_i} * {16'h0000, aux_lvl};
   wire logic [15:0] gain_ref = gain_prod[MFIO_LVL_SHIFT +: 16];
   wire logic [15:0] bias_pct = {6'h00, aux_lvl} * {8'h00, aux_bias_amount_ff};
   wire logic [25:0] bias_prod = {10'h000, bias_pct} * {16'h0000, MFIO_PCT_SCALE};
   wire logic [15:0] bias_val = bias_prod[MFIO_LVL_SHIFT +: 16];
   wire logic [15:0] bias_ref = sat_add(master_ref_i, bias_val);
   // voltage offset in volt LSBs, one per level step, two per step in the 400 V class
   wire logic [15:0] vofs_base = {6'h00, aux_lvl};
   wire logic [15:0] output_voltage_offset = class400_i ? {5'h00, aux_lvl, 1'b0}
                                             : vofs_base;

   logic [15:0] nxt_freq_ref;
   logic [15:0] nxt_volt_ref;

   always_comb begin
      nxt_freq_ref = step_ref;
      nxt_volt_ref = vf_voltage_i;
      case (aux_analog_function_ff)
         MFIO_AF_OFF: nxt_freq_ref = step_ref;
         MFIO_AF_FREF: nxt_freq_ref = step_two_sel_i ? aux_fref : master_ref_i;
         MFIO_AF_GAIN: nxt_freq_ref = step_two_sel_i ? step_ref : gain_ref;
         MFIO_AF_BIAS: nxt_freq_ref = step_two_sel_i ? step_ref : bias_ref;
         MFIO_AF_VOFS: nxt_volt_ref = sat_add(vf_voltage_i, output_voltage_offset);
         default: nxt_freq_ref = step_ref;
      endcase
   end

   // =====================================================================
   // output terminals and references
   logic [15:0] freq_ref_ff;
   logic [15:0] volt_ref_ff;
   logic relay_ff;
   logic oc1_ff;
   logic oc2_ff;

   wire logic nxt_relay = term_sel(relay_output_function_ff, status_i);
   wire logic nxt_oc1 = term_sel(first_open_collector_function_ff, status_i);
   wire logic nxt_oc2 = term_sel(second_open_collector_function_ff, status_i);

   always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         freq_ref_ff <= 16'h0000;
         volt_ref_ff <= 16'h0000;
         relay_ff <= 1'b0;
         oc1_ff <= 1'b0;
         oc2_ff <= 1'b0;
      end else begin
         freq_ref_ff <= nxt_freq_ref;
         volt_ref_ff <= nxt_volt_ref;
         relay_ff <= nxt_relay;
         oc1_ff <= nxt_oc1;
         oc2_ff <= nxt_oc2;
      end
   end

   assign term_state = {oc2_ff, oc1_ff, !relay_ff, relay_ff};
   assign freq_ref_o = freq_ref_ff;
   assign volt_ref_o = volt_ref_ff;
   assign relay_contact_a_o = relay_ff;
   assign relay_contact_b_o = !relay_ff;
   assign open_collector_one_o = oc1_ff;
   assign open_collector_two_o = oc2_ff;

   // =====================================================================
   // assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_ff);

   a_aux_off_ignored: assert property (
      aux_analog_function_ff == MFIO_AF_OFF
      |=> freq_ref_o == $past(step_ref) && volt_ref_o == $past(vf_voltage_i))
      else $error("aux input leaked while disabled");
   a_aux_step_two: assert property (
      aux_analog_function_ff == MFIO_AF_FREF && step_two_sel_i
      |=> freq_ref_o == {$past(aux_lvl), 6'h00})
      else $error("aux reference not used for step two");
   a_gain_scaled: assert property (
      aux_analog_function_ff == MFIO_AF_GAIN && !step_two_sel_i
      |=> freq_ref_o <= $past(master_ref_i))
      else $error("gain mode exceeded master reference");
   a_bias_added: assert property (
      aux_analog_function_ff == MFIO_AF_BIAS && !step_two_sel_i
      |=> freq_ref_o >= $past(master_ref_i))
      else $error("bias mode lowered the reference");
   a_vofs_added: assert property (
      aux_analog_function_ff == MFIO_AF_VOFS && !class400_i && vf_voltage_i < 16'hF000
      |=> volt_ref_o == $past(vf_voltage_i) + {6'h00, $past(aux_lvl)})
      else $error("voltage offset wrong");
   a_vofs_double: assert property (
      aux_analog_function_ff == MFIO_AF_VOFS && class400_i && vf_voltage_i < 16'hF000
      |=> volt_ref_o == $past(vf_voltage_i) + {5'h00, $past(aux_lvl), 1'b0})
      else $error("400 V offset not doubled");
   a_type_range: assert property (
      aux_analog_signal_type_ff <= MFIO_MAX_AUX_TYPE)
      else $error("signal type out of range");
   a_bias_range: assert property (
      aux_bias_amount_ff <= MFIO_MAX_AUX_BIAS)
      else $error("bias amount out of range");
   a_relay_fault: assert property (
      relay_output_function_ff == MFIO_OC_FAULT && $stable(relay_output_function_ff)
      |=> relay_contact_a_o == $past(status_i.fault))
      else $error("relay does not follow fault");
   a_relay_pair: assert property (
      relay_contact_b_o == !relay_contact_a_o)
      else $error("relay contacts not complementary");
   a_fdet_level: assert property (
      first_open_collector_function_ff == MFIO_OC_FDET1
      && status_i.out_freq >= status_i.frequency_detect_level
      |=> open_collector_one_o)
      else $error("frequency detection missed");
   a_undef_open: assert property (
      second_open_collector_function_ff > MFIO_OC_MOTOR2 |=> !open_collector_two_o)
      else $error("undefined code drove terminal");
   a_run_output: assert property (
      first_open_collector_function_ff == MFIO_OC_RUN
      && (status_i.run_cmd || status_i.volt_out) |=> open_collector_one_o)
      else $error("operating output missed");
   a_relay_minor: assert property (
      relay_output_function_ff == MFIO_OC_MINOR
      |=> relay_contact_a_o == $past(status_i.minor_alarm))
      else $error("minor alarm output wrong");
   a_oc2_agree: assert property (
      second_open_collector_function_ff == MFIO_OC_AGREE
      |=> open_collector_two_o == $past(status_i.freq_agree))
      else $error("frequency agree output wrong");
   a_relay_zero_speed: assert property (
      relay_output_function_ff == MFIO_OC_ZERO
      |=> relay_contact_a_o == ($past(status_i.out_freq) < $past(status_i.min_freq)))
      else $error("zero speed output wrong");
   a_oc1_torque_nc: assert property (
      first_open_collector_function_ff == MFIO_OC_OT_NC
      |=> open_collector_one_o == !$past(status_i.overtorque))
      else $error("overtorque closed contact wrong");
   a_relay_base_block: assert property (
      relay_output_function_ff == MFIO_OC_BBLK
      |=> relay_contact_a_o == $past(status_i.base_block))
      else $error("base block output wrong");
   a_oc1_local: assert property (
      first_open_collector_function_ff == MFIO_OC_LOCAL
      |=> open_collector_one_o == $past(status_i.local_sel))
      else $error("local operation output wrong");
   a_oc2_ready: assert property (
      second_open_collector_function_ff == MFIO_OC_READY
      |=> open_collector_two_o == ($past(status_i.ready) && !$past(status_i.fault)))
      else $error("ready output wrong");
   a_relay_undervolt: assert property (
      relay_output_function_ff == MFIO_OC_UV
      |=> relay_contact_a_o == $past(status_i.undervolt))
      else $error("undervoltage output wrong");
   a_oc1_reverse: assert property (
      first_open_collector_function_ff == MFIO_OC_REV
      |=> open_collector_one_o == $past(status_i.reverse))
      else $error("reverse run output wrong");
   a_oc2_ref_loss: assert property (
      second_open_collector_function_ff == MFIO_OC_REFLOSS
      |=> open_collector_two_o == $past(status_i.ref_loss))
      else $error("reference loss output wrong");
   a_relay_second_motor: assert property (
      relay_output_function_ff == MFIO_OC_MOTOR2
      |=> relay_contact_a_o == $past(status_i.motor2))
      else $error("second motor output wrong");

   c_gain_mode: cover property (aux_analog_function_ff == MFIO_AF_GAIN ##1 freq_ref_o != 16'h0000);
   c_bias_mode: cover property (aux_analog_function_ff == MFIO_AF_BIAS && aux_lvl == 10'h3FF);
   c_relay_trip: cover property (!relay_contact_a_o ##1 relay_contact_a_o);
   c_cur_input: cover property (cur_mode && aux_sample_i < MFIO_CUR_ZERO);
endmodule // mfio_sel

/* File: tb/mfio_far_end.sv */
// relay and open-collector wiring as seen by the external equipment
module mfio_far_end
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic relay_a_i,
   input wire logic relay_b_i,
   input wire logic oc_one_i,
   input wire logic oc_two_i,
   output logic [3:0] seen_o,
   output logic contact_err_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // =====================================================================
   // changeover contact: one side closed at all times, never both
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seen_o <= 4'h0;
         contact_err_o <= 1'b0;
      end else begin
         seen_o <= {oc_two_i, oc_one_i, relay_b_i, relay_a_i};
         if (relay_a_i !== ~relay_b_i) contact_err_o <= 1'b1;
      end
   end
endmodule // mfio_far_end

/* File: tb/test_multifunction_io_selector.sv */
// self-checking bench for the multi-function terminal selector
module test_multifunction_io_selector
   import mfio_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b1;
   mfio_bus_req_t bus_i = '0;
   mfio_status_t status_i = '0;
   logic [9:0] aux_sample_i = 10'h000;
   logic [15:0] master_ref_i = 16'h9000;
   logic [15:0] second_step_reference_i = 16'h1234;
   logic step_two_sel_i = 1'b0;
   logic [15:0] vf_voltage_i = 16'h4000;
   logic class400_i = 1'b0;
   logic [31:0] rd_data_o;
   logic [15:0] freq_ref_o;
   logic [15:0] volt_ref_o;
   logic relay_a, relay_b, oc_one, oc_two, contact_err;
   logic [3:0] seen;
   int err_count = 0;
   int cmp_count = 0;

   always #2 sys_clk_i = ~sys_clk_i;

   mfio_sel i_mfio_sel (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
      .rd_data_o(rd_data_o), .status_i(status_i), .aux_sample_i(aux_sample_i),
      .master_ref_i(master_ref_i), .second_step_reference_i(second_step_reference_i),
      .step_two_sel_i(step_two_sel_i), .vf_voltage_i(vf_voltage_i), .class400_i(class400_i),
      .freq_ref_o(freq_ref_o), .volt_ref_o(volt_ref_o), .relay_contact_a_o(relay_a),
      .relay_contact_b_o(relay_b), .open_collector_one_o(oc_one),
      .open_collector_two_o(oc_two));

   mfio_far_end i_mfio_far_end (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .relay_a_i(relay_a),
      .relay_b_i(relay_b), .oc_one_i(oc_one), .oc_two_i(oc_two), .seen_o(seen),
      .contact_err_o(contact_err));

   // =====================================================================
   // checking and closing
   task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
      cmp_count++;
      if (seen_v !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen_v);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // =====================================================================
   // register port cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      bus_i.addr <= a;
      bus_i.wdata <= {24'h000000, d};
      bus_i.wr <= 1'b1;
      @(posedge sys_clk_i);
      bus_i.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      bus_i.addr <= a;
      bus_i.rd <= 1'b1;
      @(posedge sys_clk_i);
      bus_i.rd <= 1'b0;
      #1;
      d = rd_data_o;
   endtask

   // expected terminal level for an output code, worked out from the code list
   function automatic logic term_exp(input int c, input mfio_status_t s);
      case (c)
         0: return s.fault;
         1: return s.run_cmd | s.volt_out;
         2: return s.freq_agree;
         3: return s.out_freq < s.min_freq;
         4: return s.out_freq >= s.frequency_detect_level;
         5: return s.out_freq <= s.frequency_detect_level;
         6: return s.overtorque;
         7: return !s.overtorque;
         8: return s.undertorque;
         9: return !s.undertorque;
         10: return s.minor_alarm;
         11: return s.base_block;
         12: return s.local_sel;
         13: return !s.fault & s.ready;
         14: return s.fault_retry;
         15: return s.undervolt;
         16: return s.reverse;
         17: return s.speed_search;
         19: return s.fb_loss;
         20: return s.ref_loss;
         21: return s.overheat;
         22: return s.motor2;
         default: return 1'b0;
      endcase
   endfunction

   task automatic aux(input logic [7:0] fn, input logic typ, input logic [9:0] smp,
      input logic sel, input logic cls, input logic [15:0] ef, input logic [15:0] ev);
      wr(MFIO_ADDR_AUX_FN, fn);
      wr(MFIO_ADDR_AUX_TYPE, {7'h00, typ});
      @(posedge sys_clk_i);
      aux_sample_i <= smp;
      step_two_sel_i <= sel;
      class400_i <= cls;
      @(posedge sys_clk_i);
      #1;
      check("freq ref", freq_ref_o, ef);
      check("volt ref", volt_ref_o, ev);
   endtask

   // =====================================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [7:0] ra[6];
      logic [7:0] rv[6];
      mfio_status_t pat[3];
      // a falling edge at time zero resets the design before its first clock
      rst_b_i <= 1'b0;
      ra = '{MFIO_ADDR_RELAY_FN, MFIO_ADDR_OC1_FN, MFIO_ADDR_OC2_FN, MFIO_ADDR_AUX_FN,
         MFIO_ADDR_AUX_TYPE, MFIO_ADDR_AUX_BIAS};
      rv = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h0A};
      pat[0] = '0;
      pat[0].min_freq = 16'h0200;
      pat[0].frequency_detect_level = 16'h0100;
      pat[1] = '1;
      pat[1].out_freq = 16'h0300;
      pat[1].min_freq = 16'h0200;
      pat[1].frequency_detect_level = 16'h0300;
      pat[2] = pat[0];
      pat[2].ready = 1'b1;
      pat[2].volt_out = 1'b1;
      pat[2].out_freq = 16'h0400;
      pat[2].frequency_detect_level = 16'h0300;
      @(posedge sys_clk_i);
      #1;
      check("relay a in reset", relay_a, 1'b0);
      check("relay b in reset", relay_b, 1'b1);
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      for (int i = 0; i < 6; i++) begin
         rd(ra[i], d);
         check("reset value", d, {24'h000000, rv[i]});
      end
      rd(8'h1C, d);
      check("unmapped read", d, 32'h00000000);
      wr(MFIO_ADDR_AUX_BIAS, 8'h33);
      rd(MFIO_ADDR_AUX_BIAS, d);
      check("bias above range", d, 32'h0000000A);
      wr(MFIO_ADDR_AUX_BIAS, 8'h32);
      rd(MFIO_ADDR_AUX_BIAS, d);
      check("bias at top", d, 32'h00000032);
      wr(MFIO_ADDR_AUX_TYPE, 8'h02);
      rd(MFIO_ADDR_AUX_TYPE, d);
      check("type out of range", d, 32'h00000000);
      // every code on the relay, the neighbouring codes on the collectors
      for (int c = 0; c < 24; c++) begin
         wr(MFIO_ADDR_RELAY_FN, 8'(c));
         wr(MFIO_ADDR_OC1_FN, 8'((c + 1) % 24));
         wr(MFIO_ADDR_OC2_FN, 8'((c + 2) % 24));
         for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk_i);
            status_i <= pat[k];
            @(posedge sys_clk_i);
            #1;
            check("relay a", relay_a, term_exp(c, pat[k]));
            check("relay b", relay_b, !term_exp(c, pat[k]));
            check("collector one", oc_one, term_exp((c + 1) % 24, pat[k]));
            check("collector two", oc_two, term_exp((c + 2) % 24, pat[k]));
         end
      end
      rd(MFIO_ADDR_TERM_STAT, d);
      check("terminal state", d, 32'h0000000A);
      check("far end view", seen, 4'hA);
      aux(8'h00, 1'b0, 10'h3FF, 1'b1, 1'b0, 16'h1234, 16'h4000);
      aux(8'h00, 1'b1, 10'h3FF, 1'b0, 1'b1, 16'h9000, 16'h4000);
      aux(8'h01, 1'b0, 10'h200, 1'b1, 1'b0, 16'h8000, 16'h4000);
      aux(8'h01, 1'b0, 10'h200, 1'b0, 1'b0, 16'h9000, 16'h4000);
      aux(8'h02, 1'b0, 10'h200, 1'b0, 1'b0, 16'h4800, 16'h4000);
      aux(8'h03, 1'b0, 10'h100, 1'b0, 1'b0, 16'hAFFB, 16'h4000);
      aux(8'h03, 1'b0, 10'h3FF, 1'b0, 1'b0, 16'hFFFF, 16'h4000);
      aux(8'h04, 1'b1, 10'h100, 1'b0, 1'b0, 16'h9000, 16'h403F);
      aux(8'h04, 1'b1, 10'h100, 1'b0, 1'b1, 16'h9000, 16'h407E);
      aux(8'h04, 1'b1, 10'h0C8, 1'b0, 1'b1, 16'h9000, 16'h4000);
      aux(8'h04, 1'b0, 10'h3FF, 1'b0, 1'b1, 16'h9000, 16'h47FE);
      wr(MFIO_ADDR_AUX_FN, 8'h05);
      rd(MFIO_ADDR_AUX_FN, d);
      check("function out of range", d, 32'h00000004);
      check("contact pair", contact_err, 1'b0);
      summarize();
   end

   // a hang ends the run with a counted mismatch
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_count++;
      summarize();
   end
endmodule // test_multifunction_io_selector
